/* pkg/fp_break_pkg.sv */
// Shared types and constants for the floating-point error / break event pin.
// Assumes a single core clock domain and active-low pin levels.
package fp_break_pkg;

    // ****************************************************************
    // Pin levels
    // ****************************************************************
    localparam logic PIN_ASSERTED   = 1'h0;
    localparam logic PIN_DEASSERTED = 1'h1;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic ERR_LATCH_RESET = 1'h0;
    localparam logic BRK_LATCH_RESET = 1'h0;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {
        MODE_FP_ERROR = 2'b00,
        MODE_WAIT_BRK = 2'b01,
        MODE_BRK_HELD = 2'b10
    } pin_mode_t;

    // Platform inputs, active low as seen at the pins
    typedef struct packed {
        logic stop_clock_request_n;
        logic debug_probe_request_n;
    } platform_in_t;

    // Core-side event requests, active high
    typedef struct packed {
        logic fp_error_set;
        logic fp_error_clear;
        logic break_pending;
    } core_event_t;

endpackage

/* rtl/event_flag.sv */
// Sticky event flag with set priority over clear.
// Assumes synchronous set and clear in the core clock domain.
`timescale 1ns/1ps
module event_flag
    import fp_break_pkg::*;
#(
    parameter logic RESET_VALUE = 1'h0
) (
    input  wire logic core_clk,
    input  wire logic resetn,
    input  wire logic set,
    input  wire logic clear,
    output logic      flag
);
    logic flag_reg;
    logic flag_next;

    // Set wins so that an event in the clearing cycle is kept
    assign flag_next = set ? 1'h1 : (clear ? 1'h0 : flag_reg);

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            flag_reg <= RESET_VALUE;
        end else begin
            flag_reg <= flag_next;
        end
    end

    assign flag = flag_reg;
endmodule

/* rtl/fp_error_break_event_signal.sv */
// Drives the shared floating-point error / pending break event pin.
// Assumes platform inputs are synchronous to core_clk and active low.
//
// Summary of operation
// - With no stop-clock request, the pin goes low while a float error is latched.
// - With a stop-clock request, the pin goes low only for a pending break, never for errors.
// - Once a break is shown, the pin stays low until the stop-clock request is released.
// - A probe request during a stop-clock request counts as a break event.
`timescale 1ns/1ps
module fp_error_break_event_signal
    import fp_break_pkg::*;
(
    input  wire logic   core_clk,
    input  wire logic   resetn,
    input  platform_in_t platform_in,
    input  core_event_t  core_event,
    output logic         fp_error_break_event_out,
    output logic         float_error_report,
    output logic         pending_break_report,
    output pin_mode_t    pin_mode
);

    // ****************************************************************
    // Input decode
    // ****************************************************************
    wire logic stop_clock_request;
    wire logic debug_probe_request;
    wire logic break_cause;
    wire logic fp_error_flag;

    assign stop_clock_request  = (platform_in.stop_clock_request_n == PIN_ASSERTED);
    assign debug_probe_request = (platform_in.debug_probe_request_n == PIN_ASSERTED);
    // Probe requests only count while a stop is requested
    assign break_cause = stop_clock_request &&
                         (core_event.break_pending || debug_probe_request);

    // ****************************************************************
    // Error latch
    // ****************************************************************
    // Error stays latched across a stop so it reappears after release
    event_flag #(
        .RESET_VALUE (ERR_LATCH_RESET)
    ) u_err_flag (
        .core_clk (core_clk),
        .resetn   (resetn),
        .set      (core_event.fp_error_set),
        .clear    (core_event.fp_error_clear),
        .flag     (fp_error_flag)
    );

    // ****************************************************************
    // Mode state machine
    // ****************************************************************
    // Reports are registered beside the pin so the two never disagree by a cycle
    pin_mode_t mode_reg;
    pin_mode_t mode_next;
    logic      pin_reg;
    logic      pin_next;
    logic      err_rep_reg;
    logic      brk_rep_reg;

    // A stop with a cause in the same cycle goes straight to held, so the far
    // side never sees a deasserted gap between an error and a break.
    // The error latch is left alone here; it reappears once the stop ends.
    always_comb begin
        mode_next = mode_reg;
        case (mode_reg)
            MODE_FP_ERROR: begin
                if (break_cause) begin
                    mode_next = MODE_BRK_HELD;
                end else if (stop_clock_request) begin
                    mode_next = MODE_WAIT_BRK;
                end
            end
            MODE_WAIT_BRK: begin
                if (!stop_clock_request) begin
                    mode_next = MODE_FP_ERROR;
                end else if (break_cause) begin
                    mode_next = MODE_BRK_HELD;
                end
            end
            MODE_BRK_HELD: begin
                if (!stop_clock_request) begin
                    mode_next = MODE_FP_ERROR;
                end
            end
            default: begin
                mode_next = MODE_FP_ERROR;
            end
        endcase
    end

    // Pin follows the next mode so it reacts one edge after its cause
    assign pin_next = (mode_next == MODE_BRK_HELD) ||
                      ((mode_next == MODE_FP_ERROR) && fp_error_flag);

    // Reset leaves the pin deasserted so the platform sees no false event
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            mode_reg    <= MODE_FP_ERROR;
            pin_reg     <= 1'h0;
            err_rep_reg <= ERR_LATCH_RESET;
            brk_rep_reg <= BRK_LATCH_RESET;
        end else begin
            mode_reg    <= mode_next;
            pin_reg     <= pin_next;
            err_rep_reg <= (mode_next == MODE_FP_ERROR) && fp_error_flag;
            brk_rep_reg <= (mode_next == MODE_BRK_HELD);
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Pin and reports come from flops so the far side never sees a glitch
    assign fp_error_break_event_out = pin_reg ? PIN_ASSERTED : PIN_DEASSERTED;
    assign float_error_report       = err_rep_reg;
    assign pending_break_report     = brk_rep_reg;
    assign pin_mode                 = mode_reg;

    // ****************************************************************
    // Checks
    // ****************************************************************
    AST_ERR_SHOWN: assert property (@(posedge core_clk) disable iff (!resetn)
        (!stop_clock_request && !$past(stop_clock_request) && fp_error_flag && $past(fp_error_flag))
        |=> (fp_error_break_event_out == PIN_ASSERTED))
        else $error("float error not shown on pin");

    AST_NO_ERR_IN_STOP: assert property (@(posedge core_clk) disable iff (!resetn)
        (stop_clock_request && !break_cause && mode_reg != MODE_BRK_HELD)
        |=> (fp_error_break_event_out == PIN_DEASSERTED))
        else $error("pin low during stop without break");

    AST_BRK_HOLD: assert property (@(posedge core_clk) disable iff (!resetn)
        (pending_break_report && stop_clock_request)
        |=> pending_break_report && (fp_error_break_event_out == PIN_ASSERTED))
        else $error("break released while stop still requested");

    AST_BRK_END: assert property (@(posedge core_clk) disable iff (!resetn)
        (!stop_clock_request) |=> !pending_break_report)
        else $error("break held after stop release");

    AST_PROBE_BRK: assert property (@(posedge core_clk) disable iff (!resetn)
        (stop_clock_request && debug_probe_request) |=> pending_break_report)
        else $error("probe request in stop not shown as break");

    AST_PROBE_NO_STOP: assert property (@(posedge core_clk) disable iff (!resetn)
        (!stop_clock_request && !fp_error_flag) |=> (fp_error_break_event_out == PIN_DEASSERTED))
        else $error("pin low without stop or error");

    AST_ERR_KIND: assert property (@(posedge core_clk) disable iff (!resetn)
        !(float_error_report && pending_break_report))
        else $error("both report kinds at once");

    AST_PIN_LEVEL: assert property (@(posedge core_clk) disable iff (!resetn)
        (fp_error_break_event_out == PIN_ASSERTED) == (float_error_report || pending_break_report))
        else $error("pin level disagrees with reports");

    // ****************************************************************
    // Error meaning checks
    // ****************************************************************
    AST_ERR_REPORT: assert property (@(posedge core_clk) disable iff (!resetn)
        (!stop_clock_request && fp_error_flag)
        |=> float_error_report)
        else $error("latched float error not reported");

    AST_ERR_GONE: assert property (@(posedge core_clk) disable iff (!resetn)
        (!stop_clock_request && !fp_error_flag)
        |=> !float_error_report)
        else $error("float error reported with latch clear");

    AST_ERR_NOT_IN_STOP: assert property (@(posedge core_clk) disable iff (!resetn)
        stop_clock_request
        |=> !float_error_report)
        else $error("float error reported during stop");

    // A stop with no cause must blank a shown error on the next edge
    AST_STOP_ENTRY: assert property (@(posedge core_clk) disable iff (!resetn)
        ($rose(stop_clock_request) && !break_cause)
        |=> (fp_error_break_event_out == PIN_DEASSERTED))
        else $error("error still shown after stop entry");

    // ****************************************************************
    // Break meaning checks
    // ****************************************************************
    // A break may only start from a cause sampled while a stop stood
    AST_BRK_NEEDS_CAUSE: assert property (@(posedge core_clk) disable iff (!resetn)
        $rose(pending_break_report)
        |-> $past(break_cause))
        else $error("break shown without a cause in stop");

    AST_CORE_BRK: assert property (@(posedge core_clk) disable iff (!resetn)
        (stop_clock_request && core_event.break_pending)
        |=> (pending_break_report && (fp_error_break_event_out == PIN_ASSERTED)))
        else $error("core break in stop not shown");

    AST_PROBE_IGNORED: assert property (@(posedge core_clk) disable iff (!resetn)
        (!stop_clock_request && debug_probe_request)
        |=> !pending_break_report)
        else $error("probe request shown as break without stop");

    // The spare encoding is never entered, even through the default arm
    AST_MODE_LEGAL: assert property (@(posedge core_clk) disable iff (!resetn)
        pin_mode inside {MODE_FP_ERROR, MODE_WAIT_BRK, MODE_BRK_HELD})
        else $error("pin mode left the legal codes");

    // Stop modes are only reached from a stop that was sampled
    AST_WAIT_STOP: assert property (@(posedge core_clk) disable iff (!resetn)
        (pin_mode == MODE_WAIT_BRK)
        |-> $past(stop_clock_request))
        else $error("waiting for break without a stop");

    AST_HELD_STOP: assert property (@(posedge core_clk) disable iff (!resetn)
        (pin_mode == MODE_BRK_HELD)
        |-> $past(stop_clock_request))
        else $error("break held without a stop");

endmodule

/* tb/chipset_model.sv */
// Behavioural platform logic that drives the stop-clock and probe requests.
// Assumes the bench asks for stop and probe through plain active-high controls.
`timescale 1ns/1ps
module chipset_model
    import fp_break_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       resetn,
    input  wire logic       want_stop,
    input  wire logic       want_probe,
    input  wire logic [3:0] release_delay,
    input  wire logic       pin,
    output platform_in_t    plat
);
    logic [3:0] wait_reg;
    logic       done_reg;
    logic       stop_prev_reg;
    wire logic  break_seen;
    // The pin only means break once the device has sampled the stop request;
    // in the first stopped cycle it may still be showing a float error
    assign break_seen = !plat.stop_clock_request_n && !stop_prev_reg
                        && (pin === PIN_ASSERTED);
    // ****************************************************************
    // Stop-clock sequencing
    // ****************************************************************
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            plat          <= '1;
            wait_reg      <= 4'h0;
            done_reg      <= 1'h0;
            stop_prev_reg <= 1'h1;
        end else begin
            plat.debug_probe_request_n <= !want_probe;
            stop_prev_reg              <= plat.stop_clock_request_n;
            wait_reg <= break_seen ? wait_reg + 4'h1 : 4'h0;
            if (!want_stop) begin
                plat.stop_clock_request_n <= 1'h1;
                done_reg                  <= 1'h0;
            end else if (break_seen && wait_reg == release_delay) begin
                // Slow answers are exercised by a longer delay
                plat.stop_clock_request_n <= 1'h1;
                done_reg                  <= 1'h1;
            end else if (!done_reg) begin
                plat.stop_clock_request_n <= 1'h0;
            end
        end
    end
endmodule

/* tb/fp_error_break_event_signal_tb.sv */
// Self-checking bench for the shared error / break event pin.
// Assumes the platform model drives the requests; core events come from here.
`timescale 1ns/1ps
module fp_error_break_event_signal_tb;
    import fp_break_pkg::*;
    logic         core_clk   = 1'h0;
    logic         resetn     = 1'h0;
    logic         want_stop  = 1'h0;
    logic         want_probe = 1'h0;
    logic [3:0]   rel_dly    = 4'h0;
    core_event_t  ev         = '0;
    platform_in_t plat;
    logic         pin;
    logic         err_rep;
    logic         brk_rep;
    pin_mode_t    mode;
    int           n_errors     = 0;
    int           total_checks = 0;
    always #12.5 core_clk = ~core_clk;
    chipset_model i_chipset (.core_clk(core_clk), .resetn(resetn), .want_stop(want_stop),
        .want_probe(want_probe), .release_delay(rel_dly), .pin(pin), .plat(plat));
    fp_error_break_event_signal i_dut (.core_clk(core_clk), .resetn(resetn),
        .platform_in(plat), .core_event(ev), .fp_error_break_event_out(pin),
        .float_error_report(err_rep), .pending_break_report(brk_rep), .pin_mode(mode));
    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic chk(input string what, input logic [1:0] exp, input logic [1:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic complete_run;
        if (n_errors == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // Bounded so a stuck pin ends the run instead of hanging it
    task automatic wait_pin(input logic v);
        for (int i = 0; i < 12 && pin !== v; i++) @(negedge core_clk);
        if (pin !== v) begin
            chk("pin wait", {1'h0, v}, {1'h0, pin});
            complete_run();
        end
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_error;
        // Set and clear together: the new error must win
        @(posedge core_clk) ev.fp_error_set <= 1'h1;
        ev.fp_error_clear <= 1'h1;
        @(posedge core_clk) ev.fp_error_set <= 1'h0;
        ev.fp_error_clear <= 1'h0;
        cyc(2);
        chk("error pin", 2'h0, pin);
        chk("error report", 2'h1, err_rep);
    endtask
    task automatic t_error_in_stop;
        @(posedge core_clk) want_stop <= 1'h1;
        wait_pin(1'h1);
        cyc(3);
        chk("stop pin", 2'h1, pin);
        chk("stop mode", MODE_WAIT_BRK, mode);
        chk("stop reports", 2'h0, {err_rep, brk_rep});
        @(posedge core_clk) want_stop <= 1'h0;
        wait_pin(1'h0);
        chk("error back", 2'h1, err_rep);
        @(posedge core_clk) ev.fp_error_clear <= 1'h1;
        @(posedge core_clk) ev.fp_error_clear <= 1'h0;
        wait_pin(1'h1);
        chk("error cleared", 2'h0, err_rep);
    endtask
    task automatic t_probe_break;
        rel_dly <= 4'h6;
        @(posedge core_clk) want_stop <= 1'h1;
        cyc(4);
        @(posedge core_clk) want_probe <= 1'h1;
        wait_pin(1'h0);
        chk("probe mode", MODE_BRK_HELD, mode);
        chk("break report", 2'h1, brk_rep);
        @(posedge core_clk) want_probe <= 1'h0;
        cyc(4);
        chk("held pin", 2'h0, {plat.stop_clock_request_n, pin});
        wait_pin(1'h1);
        chk("release order", 2'h1, plat.stop_clock_request_n);
        @(posedge core_clk) want_stop <= 1'h0;
    endtask
    task automatic t_core_break;
        rel_dly <= 4'h0;
        @(posedge core_clk) ev.break_pending <= 1'h1;
        want_probe <= 1'h1;
        cyc(4);
        chk("no stop pin", 2'h1, pin);
        chk("no stop mode", MODE_FP_ERROR, mode);
        @(posedge core_clk) want_probe <= 1'h0;
        want_stop <= 1'h1;
        wait_pin(1'h0);
        chk("core break", 2'h1, brk_rep);
        @(posedge core_clk) ev.break_pending <= 1'h0;
        wait_pin(1'h1);
        @(posedge core_clk) want_stop <= 1'h0;
        cyc(2);
    endtask
    initial begin
        cyc(20);
        chk("reset pin", 2'h1, pin);
        chk("reset state", 2'h0, {mode == MODE_FP_ERROR ? 1'h0 : 1'h1, err_rep | brk_rep});
        @(posedge core_clk) resetn <= 1'h1;
        cyc(2);
        t_error();
        t_error_in_stop();
        t_probe_break();
        t_core_break();
        complete_run();
    end
endmodule
